// ===== hw/event_host_ctrl.sv
// processor-side controller: AXI4-Lite registers driving the event link
`timescale 1ns/1ps
`default_nettype none
module event_host_ctrl
    import event_pkg::*;
(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // link to the device
    event_link_if.host       link,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef struct packed {
        host_state_t st;
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        cmd_valid;
        logic [7:0]  cmd_code;
        logic [15:0] cmd_wdata;
        logic [15:0] last_rdata;
        logic [15:0] cause;
        logic [7:0]  otg_code;
        logic [7:0]  oper_code;
    } host_regs_t;

    host_regs_t s;
    host_regs_t n;
    logic       idle;

    assign idle = (s.st == ST_IDLE) && !s.cmd_valid;

    always_comb begin
        n           = s;
        n.cmd_valid = 1'b0;
        // address and data are taken independently
        if (s_axi_awvalid && s.awready) begin
            n.aw_have = 1'b1;
            n.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_have = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // commit a write once both halves are held
        if (n.aw_have && n.w_have && !s.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            case (n.awaddr)
                OFS_CMD: begin
                    // a command while busy is dropped; check busy first
                    if (idle) begin
                        n.cmd_valid = 1'b1;
                        n.cmd_code  = n.wdata[7:0];
                        n.cmd_wdata = n.wdata[31:16];
                    end
                end
                OFS_CLEAR_ALL: begin
                    if (idle) begin
                        n.cmd_valid = 1'b1;
                        n.cmd_code  = CMD_STATUS_WRITE;
                        n.cmd_wdata = CLEAR_ALL_VALUE; // RQ4
                    end
                end
                OFS_FOLLOW: begin
                    if (n.wstrb[0]) begin
                        n.otg_code = n.wdata[7:0];
                    end
                    if (n.wstrb[1]) begin
                        n.oper_code = n.wdata[15:8];
                    end
                end
                OFS_STATUS, OFS_RDATA, OFS_CAUSE: begin
                    n.bresp = RESP_OKAY;
                end
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready  = !n.w_have && !n.bvalid;

        // link sequencing: one command in flight at a time
        case (s.st)
            ST_IDLE: begin
                if (s.cmd_valid) begin
                    n.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (link.rsp_valid) begin
                    n.last_rdata = link.rsp_rdata;
                    n.st         = ST_IDLE;
                    // status read: chase the cause register of the event
                    if (s.cmd_code == CMD_STATUS_READ) begin
                        if (link.rsp_rdata[BIT_OTG] && s.otg_code != 8'h00) begin
                            n.cmd_valid = 1'b1; // RQ5
                            n.cmd_code  = s.otg_code;
                            n.st        = ST_FOLLOW;
                        end else if (link.rsp_rdata[BIT_OPER] && s.oper_code != 8'h00) begin
                            n.cmd_valid = 1'b1; // RQ11
                            n.cmd_code  = s.oper_code;
                            n.st        = ST_FOLLOW;
                        end
                    end
                end
            end
            ST_FOLLOW: begin
                if (link.rsp_valid) begin
                    n.cause = link.rsp_rdata;
                    n.st    = ST_IDLE;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        // reads answer one cycle after the address is taken
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                OFS_STATUS:    n.rdata = {29'h0, s.st == ST_FOLLOW, link.host_irq_pin, !idle};
                OFS_RDATA:     n.rdata = {16'h0000, s.last_rdata};
                OFS_CAUSE:     n.rdata = {16'h0000, s.cause};
                OFS_FOLLOW:    n.rdata = {16'h0000, s.oper_code, s.otg_code};
                OFS_CMD, OFS_CLEAR_ALL: n.rdata = 32'h0000_0000;
                default: begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end
        n.arready = !n.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s           <= '0;
            s.st        <= ST_IDLE;
            s.otg_code  <= OTG_CAUSE_CODE_RST;
            s.oper_code <= OPER_CAUSE_CODE_RST;
        end else if (ce) begin
            s <= n;
        end
    end

    // outputs straight from flops
    assign s_axi_awready  = s.awready;
    assign s_axi_wready   = s.wready;
    assign s_axi_bvalid   = s.bvalid;
    assign s_axi_bresp    = s.bresp;
    assign s_axi_arready  = s.arready;
    assign s_axi_rvalid   = s.rvalid;
    assign s_axi_rdata    = s.rdata;
    assign s_axi_rresp    = s.rresp;
    assign link.cmd_valid = s.cmd_valid;
    assign link.cmd_code  = s.cmd_code;
    assign link.cmd_wdata = s.cmd_wdata;
endmodule
`default_nettype wire

// ===== hw/event_link_if.sv
// command link between the event status device and its controlling processor
`timescale 1ns/1ps
`default_nettype none
interface event_link_if;
    import event_pkg::*;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata;
    logic        rsp_valid;
    logic [15:0] rsp_rdata;
    logic        host_irq_pin;
    modport dev (
        input  cmd_valid, cmd_code, cmd_wdata,
        output rsp_valid, rsp_rdata, host_irq_pin
    );
    modport host (
        output cmd_valid, cmd_code, cmd_wdata,
        input  rsp_valid, rsp_rdata, host_irq_pin
    );
endinterface
`default_nettype wire

// ===== hw/event_pkg.sv
// constants and types shared by the event status device and its host-side controller
package event_pkg;
    // link command codes
    localparam logic [7:0] CMD_STATUS_READ  = 8'h24;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'hA4;
    localparam logic [15:0] CLEAR_ALL_VALUE = 16'h00FF;
    // flag layout of host_cpu_event_status
    localparam int FLAG_COUNT      = 10;
    localparam int BIT_OTG         = 9;
    localparam int BIT_ASYNC_DONE  = 8;
    localparam int BIT_INTR_DONE   = 7;
    localparam int BIT_CLOCK_READY = 6;
    localparam int BIT_SUSPENDED   = 5;
    localparam int BIT_OPER        = 4;
    localparam int BIT_ALL_XFER    = 3;
    localparam int BIT_ISO_BUF1    = 2;
    localparam int BIT_ISO_BUF0    = 1;
    localparam int BIT_SOF         = 0;
    localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 10'h000;
    localparam logic [5:0] RESERVED_READ = 6'h00;
    localparam int HW_CFG_IRQ_EN_BIT = 0;
    // controller register map, byte offsets
    localparam logic [7:0] OFS_CMD       = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_RDATA     = 8'h08;
    localparam logic [7:0] OFS_CAUSE     = 8'h0C;
    localparam logic [7:0] OFS_CLEAR_ALL = 8'h10;
    localparam logic [7:0] OFS_FOLLOW    = 8'h14;
    // follow-up read codes after reset; zero turns the follow-up read off until software reprograms them
    localparam logic [7:0] OTG_CAUSE_CODE_RST = 8'h00;
    localparam logic [7:0] OPER_CAUSE_CODE_RST = 8'h00;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // controller states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_WAIT   = 3'b010,
        ST_FOLLOW = 3'b100
    } host_state_t;
endpackage

// ===== hw/event_status_dev.sv
// host processor event status register with interrupt pin
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1: flags reset to zero, bits 15-10 reserved
// RQ2: pin needs flag, mask bit and global enable
// RQ3: read keeps flags; write one clears a flag
// RQ4: driver writes FFH to clear all flags; here FFH clears only bits 7:0, so bits 9 and 8 stay set
// RQ5: bit 9 on OTG event; read cause
// RQ6: bit 8 on async threshold or timeout
// RQ7: bit 7 on last descriptor with ack
// RQ8: bit 6 when woken clock runs again
// RQ9: suspend via control bits 7:6; sets bit 5
// RQ10: no start-of-frame sent while suspended
// RQ11: bit 4 on operational event; read cause
// RQ12: bit 3 on counter zero or end pin
// RQ13: bit 2 on iso buffer one done
// RQ14: bit 1 on iso buffer zero done
// RQ15: bit 0 at start of frame
// RQ16: zero writes keep flags; reserved reads zero
module event_status_dev
    import event_pkg::*;
(
    // clock, reset, enable
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    // link to the processor
    event_link_if.dev                  link,
    // interrupt gating, held outside this block
    input  wire logic [FLAG_COUNT-1:0] host_cpu_event_mask,
    input  wire logic [15:0]           host_hw_config_reg,
    // suspend control, bits 7:6 of host_control_reg
    input  wire logic [1:0]            suspend_ctrl,
    input  wire logic                  wake_clock_on,
    // event sources, one-cycle pulses
    input  wire logic                  otg_event,
    input  wire logic                  async_count_hit,
    input  wire logic                  async_timeout_hit,
    input  wire logic                  intr_ack_seen,
    input  wire logic                  intr_list_last,
    input  wire logic                  oper_event,
    input  wire logic                  xfer_count_zero,
    input  wire logic                  end_of_transfer_pin,
    input  wire logic                  iso_buf1_last,
    input  wire logic                  iso_buf0_last,
    input  wire logic                  sof_state_enter,
    // frame and power status
    output logic                       sof_tx,
    output logic                       suspended
);
    typedef struct packed {
        logic        suspended;
        logic        ack_seen;
        logic        irq;
        logic        rsp_valid;
        logic [15:0] rsp_rdata;
        logic        sof_tx;
    } dev_state_t;

    dev_state_t            state_reg;
    dev_state_t            state_next;
    logic [FLAG_COUNT-1:0] flags;
    logic [FLAG_COUNT-1:0] set_pulse;
    logic [FLAG_COUNT-1:0] clr_mask;
    logic                  write_cmd;
    logic                  read_cmd;
    logic                  enter_suspend;
    logic                  leave_suspend;

    // command decode; only the write code touches flags
    assign write_cmd = link.cmd_valid && (link.cmd_code == CMD_STATUS_WRITE);
    assign read_cmd  = link.cmd_valid && (link.cmd_code == CMD_STATUS_READ);

    // reserved bits of the write are simply not wired to the flag bank
    assign clr_mask = write_cmd ? link.cmd_wdata[FLAG_COUNT-1:0] : '0; // RQ3 RQ16

    // suspend entry needs both control bits, exit needs the clock back
    assign enter_suspend = !state_reg.suspended && (suspend_ctrl == 2'h3); // RQ9
    assign leave_suspend = state_reg.suspended && wake_clock_on; // RQ8

    // event sources into flag positions
    always_comb begin
        set_pulse                  = '0;
        set_pulse[BIT_OTG]         = otg_event; // RQ5
        set_pulse[BIT_ASYNC_DONE]  = async_count_hit | async_timeout_hit; // RQ6
        // ack seen earlier in the list or on the last descriptor itself
        set_pulse[BIT_INTR_DONE]   = intr_list_last &
                                     (state_reg.ack_seen | intr_ack_seen); // RQ7
        set_pulse[BIT_CLOCK_READY] = leave_suspend; // RQ8
        set_pulse[BIT_SUSPENDED]   = enter_suspend; // RQ9
        set_pulse[BIT_OPER]        = oper_event; // RQ11
        set_pulse[BIT_ALL_XFER]    = xfer_count_zero | end_of_transfer_pin; // RQ12
        set_pulse[BIT_ISO_BUF1]    = iso_buf1_last; // RQ13
        set_pulse[BIT_ISO_BUF0]    = iso_buf0_last; // RQ14
        // a sleeping controller never enters the frame state
        set_pulse[BIT_SOF]         = sof_state_enter & ~state_reg.suspended; // RQ15
    end

    sticky_flags u_flags (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .set_pulse (set_pulse),
        .clr_mask  (clr_mask),
        .flags     (flags)
    );

    // next state of the interface side
    always_comb begin
        state_next = state_reg;

        // suspend tracking
        if (enter_suspend) begin
            state_next.suspended = 1'b1; // RQ9
        end else if (leave_suspend) begin
            state_next.suspended = 1'b0;
        end

        // ack memory spans one pass of the interrupt list
        if (intr_list_last) begin
            state_next.ack_seen = 1'b0;
        end else if (intr_ack_seen) begin
            state_next.ack_seen = 1'b1;
        end

        // pin is registered so it is glitch free; one cycle behind the flags
        state_next.irq = (|(flags & host_cpu_event_mask)) &&
                         host_hw_config_reg[HW_CFG_IRQ_EN_BIT]; // RQ2

        // every command gets one answer pulse; unknown codes read zero
        state_next.rsp_valid = link.cmd_valid;
        if (read_cmd) begin
            state_next.rsp_rdata = {RESERVED_READ, flags}; // RQ3 RQ16
        end else if (link.cmd_valid) begin
            state_next.rsp_rdata = 16'h0000;
        end

        // frames stop going out once suspended
        state_next.sof_tx = sof_state_enter && !state_reg.suspended &&
                            !enter_suspend; // RQ10
    end

    // single register for the whole interface state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg.suspended <= 1'b0;
            state_reg.ack_seen  <= 1'b0;
            state_reg.irq       <= 1'b0;
            state_reg.rsp_valid <= 1'b0;
            state_reg.rsp_rdata <= 16'h0000;
            state_reg.sof_tx    <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign link.host_irq_pin = state_reg.irq;
    assign link.rsp_valid    = state_reg.rsp_valid;
    assign link.rsp_rdata    = state_reg.rsp_rdata;
    assign sof_tx            = state_reg.sof_tx;
    assign suspended         = state_reg.suspended;
endmodule
`default_nettype wire

// ===== hw/sticky_flags.sv
// bank of sticky event flags, cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module sticky_flags
    import event_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    // set and clear
    input  wire logic [FLAG_COUNT-1:0] set_pulse,
    input  wire logic [FLAG_COUNT-1:0] clr_mask,
    // flags
    output logic      [FLAG_COUNT-1:0] flags
);
    typedef struct packed {
        logic [FLAG_COUNT-1:0] flags;
    } flag_state_t;

    flag_state_t               state_reg;
    flag_state_t               state_next;
    logic [FLAG_COUNT-1:0]     bit_next;

    // per bit: a new event beats a clear in the same cycle
    genvar i;
    for (i = 0; i < FLAG_COUNT; i++) begin : g_bit
        assign bit_next[i] = set_pulse[i] | (state_reg.flags[i] & ~clr_mask[i]); // RQ3 RQ16
    end

    always_comb begin
        state_next       = state_reg;
        state_next.flags = bit_next;
    end

    // flags come up clear so nothing fires at power-on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg.flags <= FLAGS_RESET; // RQ1
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;
endmodule
`default_nettype wire

// ===== tb/event_link_chk.sv
// link protocol checker for the event status device and its controller
`timescale 1ns/1ps
`default_nettype none
module event_link_chk
    import event_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // link signals
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic        host_irq_pin
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // answer timing: exactly one answer, one edge after each command
    chk_rsp_on_time: assert property (cmd_valid |=> rsp_valid)
        else $error("link answer missing");
    chk_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("link answer without command");
    chk_rsp_single: assert property (rsp_valid |=> !rsp_valid)
        else $error("link answer too long");
    chk_cmd_spacing: assert property (cmd_valid |=> !cmd_valid)
        else $error("commands too close");

    // answer contents
    chk_reserved_zero: assert property (rsp_valid |-> rsp_rdata[15:10] == RESERVED_READ)
        else $error("reserved bits not zero");
    chk_nonread_zero: assert property (
        cmd_valid && cmd_code != CMD_STATUS_READ |=> rsp_rdata == 16'h0000)
        else $error("non-read answer not zero");
    chk_rdata_holds: assert property (!$past(cmd_valid) |-> $stable(rsp_rdata))
        else $error("answer data changed");

    // leaving reset the link is quiet and the pin low
    chk_reset_quiet: assert property (
        $rose(aresetn) |-> !rsp_valid && !host_irq_pin && !cmd_valid)
        else $error("link busy after reset");

    // main scenarios
    cov_read: cover property (cmd_valid && cmd_code == CMD_STATUS_READ);
    cov_clear_all: cover property (
        cmd_valid && cmd_code == CMD_STATUS_WRITE && cmd_wdata == CLEAR_ALL_VALUE);
    cov_irq: cover property ($rose(host_irq_pin));
endmodule
`default_nettype wire

// ===== tb/host_cpu_event_status_bench.sv
// self-checking bench joining the event status device and its controller
`timescale 1ns/1ps
`default_nettype none
module host_cpu_event_status_bench
    import event_pkg::*;
;
    // clock, reset and device-side inputs
    logic        aclk    = 1'h0;
    logic        aresetn = 1'h0;
    logic [11:0] ev      = 12'h000;
    logic [9:0]  mask    = 10'h000;
    logic [15:0] cfg     = 16'h0000;
    logic [1:0]  susp    = 2'h0;
    logic        sof_tx;
    logic        suspended;
    // register bus
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        awvalid = 1'h0;
    logic        wvalid  = 1'h0;
    logic        bready  = 1'h0;
    logic        arvalid = 1'h0;
    logic        rready  = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          mismatches   = 0;
    int          total_checks = 0;
    int          sof_seen     = 0;

    // event causes and the flag word each should leave; ack-less last first
    localparam logic [11:0] CV [11] = '{12'h010, 12'h001, 12'h002, 12'h004, 12'h018,
        12'h020, 12'h040, 12'h080, 12'h100, 12'h200, 12'h400};
    localparam logic [15:0] CE [11] = '{16'h0000, 16'h0200, 16'h0100, 16'h0100,
        16'h0080, 16'h0010, 16'h0008, 16'h0008, 16'h0004, 16'h0002, 16'h0001};

    event_link_if u_event_link_if ();

    event_status_dev u_event_status_dev (
        .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .link(u_event_link_if),
        .host_cpu_event_mask(mask), .host_hw_config_reg(cfg), .suspend_ctrl(susp),
        .wake_clock_on(ev[11]), .otg_event(ev[0]), .async_count_hit(ev[1]),
        .async_timeout_hit(ev[2]), .intr_ack_seen(ev[3]), .intr_list_last(ev[4]),
        .oper_event(ev[5]), .xfer_count_zero(ev[6]), .end_of_transfer_pin(ev[7]),
        .iso_buf1_last(ev[8]), .iso_buf0_last(ev[9]), .sof_state_enter(ev[10]),
        .sof_tx(sof_tx), .suspended(suspended));

    // full byte lanes only; the lane logic stays untested
    event_host_ctrl u_event_host_ctrl (
        .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .link(u_event_link_if),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    event_link_chk u_event_link_chk (
        .aclk(aclk), .aresetn(aresetn), .cmd_valid(u_event_link_if.cmd_valid),
        .cmd_code(u_event_link_if.cmd_code), .cmd_wdata(u_event_link_if.cmd_wdata),
        .rsp_valid(u_event_link_if.rsp_valid), .rsp_rdata(u_event_link_if.rsp_rdata),
        .host_irq_pin(u_event_link_if.host_irq_pin));

    // clock and frame-pulse counter
    always #25 aclk = ~aclk;
    always @(posedge aclk) if (sof_tx === 1'h1) sof_seen <= sof_seen + 1;

    task automatic final_report();
        if (mismatches == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        final_report();
    endtask

    // bus write: both halves offered together, each dropped once taken
    task automatic axi_w(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (n == 40) hang();
        r = bresp;
        bready <= 1'h0;
        @(posedge aclk);
    endtask

    // bus read; the spare edge at the end keeps strobes from double assignment
    task automatic axi_r(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (n == 40) hang();
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    // wait until the controller has no link command in flight
    task automatic idle();
        logic [31:0] v;
        logic [1:0]  r;
        int          n;
        for (n = 0; n < 20; n++) begin
            axi_r(OFS_STATUS, v, r);
            if (v[0] === 1'h0) break;
        end
        if (n == 20) hang();
    endtask

    task automatic link_op(input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
        logic [31:0] v;
        logic [1:0]  r;
        axi_w(OFS_CMD, {d, 8'h00, c}, r);
        idle();
        axi_r(OFS_RDATA, v, r);
        q = v[15:0];
    endtask

    task automatic expect_status(input logic [15:0] e);
        logic [15:0] q;
        link_op(CMD_STATUS_READ, 16'h0000, q);
        cmp(32'(q), 32'(e));
    endtask

    task automatic clr(input logic [15:0] m);
        logic [15:0] q;
        link_op(CMD_STATUS_WRITE, m, q);
        cmp(32'(q), 32'h0);
    endtask

    task automatic pulse(input logic [11:0] v);
        ev <= v;
        @(posedge aclk);
        ev <= 12'h000;
        @(posedge aclk);
    endtask

    task automatic t_reset();
        logic [31:0] v;
        logic [1:0]  r;
        expect_status(16'h0000);
        cmp(32'(u_event_link_if.host_irq_pin), 32'h0);
        axi_r(8'h40, v, r);
        cmp(32'(r), 32'(RESP_SLVERR));
        axi_w(8'h44, 32'h0, r);
        cmp(32'(r), 32'(RESP_SLVERR));
    endtask

    // each cause alone; reads and zero writes must keep the flag
    task automatic t_events();
        for (int i = 0; i < 11; i++) begin
            pulse(CV[i]);
            expect_status(CE[i]);
            expect_status(CE[i]);
            clr(16'h0000);
            expect_status(CE[i]);
            clr(CE[i] | 16'hFC00);
            expect_status(16'h0000);
        end
        // ack on an earlier descriptor counts
        pulse(12'h008);
        pulse(12'h010);
        expect_status(16'h0080);
        clr(16'h0080);
    endtask

    // pin only with flag, its mask bit and the global enable together
    task automatic t_irq();
        logic [31:0] v;
        logic [15:0] q;
        logic [1:0]  r;
        pulse(12'h020);
        for (int j = 0; j < 4; j++) begin
            mask <= j[0] ? 10'h010 : 10'h3EF;
            cfg <= j[1] ? 16'h0001 : 16'hFFFE;
            repeat (3) @(posedge aclk);
            cmp(32'(u_event_link_if.host_irq_pin), 32'(j == 3));
            axi_r(OFS_STATUS, v, r);
            cmp(32'(v[1]), 32'(j == 3));
        end
        axi_w(OFS_FOLLOW, 32'h0000_2400, r);
        link_op(CMD_STATUS_READ, 16'h0000, q);
        axi_r(OFS_CAUSE, v, r);
        cmp(v, 32'h0000_0010);
        clr(16'h0010);
        repeat (3) @(posedge aclk);
        cmp(32'(u_event_link_if.host_irq_pin), 32'h0);
        mask <= 10'h000;
    endtask

    task automatic t_suspend();
        int s0;
        s0 = sof_seen;
        susp <= 2'h3;
        expect_status(16'h0020);
        cmp(32'(suspended), 32'h1);
        susp <= 2'h0;
        pulse(12'h400);
        expect_status(16'h0020);
        cmp(sof_seen - s0, 32'h0);
        pulse(12'h800);
        expect_status(16'h0060);
        cmp(32'(suspended), 32'h0);
        clr(16'h0060);
        pulse(12'h400);
        expect_status(16'h0001);
        cmp(sof_seen - s0, 32'h1);
        clr(16'h0001);
    endtask

    // all causes but suspend and wake at once, unknown code, follow-up read, then clear-all
    task automatic t_clear_all();
        logic [31:0] v;
        logic [15:0] q;
        logic [1:0]  r;
        pulse(12'h7FF);
        expect_status(16'h039F);
        link_op(8'h55, 16'hFFFF, q);
        cmp(32'(q), 32'h0);
        expect_status(16'h039F);
        axi_w(OFS_FOLLOW, 32'h0000_0024, r);
        link_op(CMD_STATUS_READ, 16'h0000, q);
        axi_r(OFS_CAUSE, v, r);
        cmp(v, 32'h0000_039F);
        axi_w(OFS_FOLLOW, 32'h0, r);
        axi_w(OFS_CLEAR_ALL, 32'h0, r);
        idle();
        expect_status(16'h0300);
        clr(16'h0300);
    endtask

    // reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_events();
        t_irq();
        t_suspend();
        t_clear_all();
        final_report();
    end
endmodule
`default_nettype wire
